//--- logic/rilpc_top.sv
// reset sequencing, interrupt arbitration and low-power control
`default_nettype none
`include "rilpc_map.svh"

module rilpc_top #(
    parameter int NSRC = 16,
    parameter int LONG_CYC = `RILPC_LONG_CYC
) (
    // clock, enable and reset
    input wire logic core_clk,
    input wire logic clk_en,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // reset sources
    input wire logic power_on_pulse,
    input wire logic low_voltage_in,
    input wire logic watchdog_timeout,
    // cpu side
    input wire rilpc_pkg::rilpc_cpu_t cpu,
    output rilpc_pkg::rilpc_irq_t irq,
    // interrupt sources, index 0 highest priority
    input wire logic [NSRC-1:0] irq_req,
    input wire logic [NSRC-1:0] irq_en,
    // clock and reset controls
    output logic internal_reset,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_enable,
    output logic watchdog_enable,
    output logic watchdog_tick,
    output logic monitor_mode
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // lowest index of a set bit: highest priority
    function automatic logic [3:0] rilpc_prio(input logic [NSRC-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : rilpc_prio

    localparam logic [12:0] LONG_T = 13'(LONG_CYC);
    localparam logic [12:0] SHORT_T = 13'(`RILPC_SHORT_CYC);
    localparam logic [12:0] VEC_T = 13'(`RILPC_VEC_CYC);

    rilpc_pkg::rilpc_state_all_t s_q;
    rilpc_pkg::rilpc_state_all_t s_d;
    logic [NSRC-1:0] live;
    logic rst_cause;
    logic [7:0] set_bits;
    logic wr_ok;

    assign live = irq_req & irq_en;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.irq.take = 1'b0;
        s_d.irq.clr_mask = 1'b0;
        s_d.rvalid = 1'b0;
        s_d.wd_tick = 1'b0;
        wr_ok = avs_write && !s_q.rvalid;
        set_bits = 8'h00;
        // internal reset sources; opcode and address checks only in the run and wait states
        if (s_q.st == rilpc_pkg::RILPC_ST_RUN || s_q.st == rilpc_pkg::RILPC_ST_WAIT) begin
            if (cpu.illegal_op) begin
                set_bits[`RILPC_CAUSE_ILLEGAL_OPCODE_FLAG] = 1'b1;
            end
            if (cpu.stop_op && !s_q.cfg[`RILPC_CFG_STOPEN]) begin
                set_bits[`RILPC_CAUSE_ILLEGAL_OPCODE_FLAG] = 1'b1;
            end
            if (cpu.opcode_fetch && cpu.unmapped) begin
                set_bits[`RILPC_CAUSE_ILLEGAL_ADDRESS_FLAG] = 1'b1;
            end
        end
        if (s_q.st == rilpc_pkg::RILPC_ST_VEC && cpu.vec_fetch
            && cpu.vec_data == `RILPC_ERASED_BYTE && !s_q.monitor) begin
            set_bits[`RILPC_CAUSE_MEN] = 1'b1;
        end
        if (watchdog_timeout && s_q.st != rilpc_pkg::RILPC_ST_RESET) begin
            set_bits[`RILPC_CAUSE_WDOG] = 1'b1;
        end
        if (low_voltage_in && !s_q.cfg[`RILPC_CFG_LVPWRD]
            && !s_q.cfg[`RILPC_CFG_LVRSTD]) begin
            set_bits[`RILPC_CAUSE_LVR] = 1'b1;
        end
        rst_cause = |set_bits;

        // register bus: reads of the cause register clear its flags, set wins
        if (avs_read && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            case (avs_address)
                `RILPC_ADDR_CAUSE: begin
                    s_d.rdata = {24'h000000, s_q.cause};
                    s_d.cause = 8'h00;
                end
                `RILPC_ADDR_CONFIG: s_d.rdata = {24'h000000, s_q.cfg};
                `RILPC_ADDR_STATUS: s_d.rdata = {20'h00000, s_q.cnt};
                `RILPC_ADDR_PEND: s_d.rdata = 32'(live);
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (wr_ok && avs_address == `RILPC_ADDR_CONFIG && avs_byteenable[0]) begin
            s_d.cfg = avs_writedata[7:0];
        end
        s_d.cause = s_d.cause | set_bits;

        // watchdog tick counter advances every enabled cycle, held at zero in stop
        {s_d.wd_tick, s_d.cnt} = {1'b0, s_q.cnt} + 13'h0001;

        case (s_q.st)
            rilpc_pkg::RILPC_ST_RESET: begin
                s_d.latched = 1'b0;
                if (low_voltage_in && set_bits[`RILPC_CAUSE_LVR]) begin
                    s_d.tmr = 13'h0000; // held until voltage recovers
                end else if (s_q.tmr + 13'h0001 >= LONG_T) begin
                    s_d.tmr = 13'h0000;
                    s_d.st = rilpc_pkg::RILPC_ST_VEC;
                end else begin
                    s_d.tmr = s_q.tmr + 13'h0001;
                end
            end
            rilpc_pkg::RILPC_ST_VEC: begin
                if (s_q.tmr + 13'h0001 >= VEC_T) begin
                    s_d.tmr = 13'h0000;
                    s_d.st = rilpc_pkg::RILPC_ST_RUN;
                end else begin
                    s_d.tmr = s_q.tmr + 13'h0001;
                end
            end
            rilpc_pkg::RILPC_ST_RUN: begin
                // latch once, keep until serviced or mask set again
                if (!s_q.latched && !cpu.i_mask && |live) begin
                    s_d.latched = 1'b1;
                    s_d.lat_vec = rilpc_prio(live);
                end else if (s_q.latched && cpu.i_mask && !cpu.insn_done) begin
                    s_d.latched = 1'b0;
                end
                if (cpu.swi_op && cpu.insn_done) begin
                    s_d.irq.take = 1'b1;
                    s_d.irq.is_swi = 1'b1;
                    s_d.irq.vector = 4'h0;
                    s_d.irq.ret_pc = cpu.pc;
                end else if ((cpu.insn_done || cpu.rti_done) && !cpu.i_mask
                             && (s_q.latched || |live)) begin
                    s_d.irq.take = 1'b1;
                    s_d.irq.is_swi = 1'b0;
                    s_d.irq.vector = s_q.latched ? s_q.lat_vec : rilpc_prio(live);
                    s_d.irq.ret_pc = cpu.pc - 16'h0001;
                    s_d.latched = 1'b0;
                end else if (cpu.wait_op) begin
                    s_d.irq.clr_mask = 1'b1;
                    s_d.st = rilpc_pkg::RILPC_ST_WAIT;
                end else if (cpu.stop_op && s_q.cfg[`RILPC_CFG_STOPEN]) begin
                    s_d.irq.clr_mask = 1'b1;
                    s_d.cnt = 12'h000;
                    s_d.st = rilpc_pkg::RILPC_ST_STOP;
                end
            end
            rilpc_pkg::RILPC_ST_WAIT: begin
                if (|live) begin
                    s_d.irq.take = 1'b1;
                    s_d.irq.is_swi = 1'b0;
                    s_d.irq.vector = rilpc_prio(live);
                    s_d.irq.ret_pc = cpu.pc - 16'h0001;
                    s_d.st = rilpc_pkg::RILPC_ST_RUN;
                end
            end
            rilpc_pkg::RILPC_ST_STOP: begin
                s_d.cnt = 12'h000;
                s_d.wd_tick = 1'b0;
                if (|live) begin
                    s_d.tmr = s_q.cfg[`RILPC_CFG_SHORT_RECOVERY_SELECT] ? SHORT_T : LONG_T;
                    s_d.lat_vec = rilpc_prio(live);
                    s_d.st = rilpc_pkg::RILPC_ST_RECOV;
                end
            end
            rilpc_pkg::RILPC_ST_RECOV: begin
                if (s_q.tmr <= 13'h0001) begin
                    s_d.tmr = 13'h0000;
                    s_d.irq.take = 1'b1;
                    s_d.irq.is_swi = 1'b0;
                    s_d.irq.vector = s_q.lat_vec;
                    s_d.irq.ret_pc = cpu.pc - 16'h0001;
                    s_d.st = rilpc_pkg::RILPC_ST_RUN;
                end else begin
                    s_d.tmr = s_q.tmr - 13'h0001;
                end
            end
            default: s_d.st = rilpc_pkg::RILPC_ST_RESET;
        endcase

        // any reset cause overrides everything, long recovery always
        if (rst_cause) begin
            s_d.st = rilpc_pkg::RILPC_ST_RESET;
            s_d.tmr = 13'h0000;
            s_d.cnt = 12'h000;
            s_d.latched = 1'b0;
            s_d.irq.take = 1'b0;
            s_d.monitor = s_q.monitor | set_bits[`RILPC_CAUSE_MEN];
        end
        if (s_q.st == rilpc_pkg::RILPC_ST_STOP && rst_cause) begin
            s_d.osc_run = 1'b1;
        end else if (s_d.st == rilpc_pkg::RILPC_ST_STOP) begin
            s_d.osc_run = s_q.cfg[`RILPC_CFG_OSCSTOP];
        end else begin
            s_d.osc_run = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.st <= rilpc_pkg::RILPC_ST_RESET;
            s_q.cause <= `RILPC_CAUSE_PORVAL;
            s_q.cfg <= `RILPC_CFG_RESET;
            s_q.osc_run <= 1'b1;
        end else if (power_on_pulse) begin
            s_q <= '0;
            s_q.st <= rilpc_pkg::RILPC_ST_RESET;
            s_q.cause <= `RILPC_CAUSE_PORVAL;
            s_q.cfg <= `RILPC_CFG_RESET;
            s_q.osc_run <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // reads wait one cycle; a frozen block holds every request off
    assign avs_waitrequest = (avs_read && !(s_q.rvalid && clk_en)) || (avs_write && !clk_en);
    assign avs_readdata = s_q.rdata;
    assign irq = s_q.irq;
    assign internal_reset = (s_q.st == rilpc_pkg::RILPC_ST_RESET)
                          || (s_q.st == rilpc_pkg::RILPC_ST_VEC);
    // cpu clock stops in every low-power state
    assign cpu_clk_en = (s_q.st == rilpc_pkg::RILPC_ST_RUN);
    assign periph_clk_en = (s_q.st == rilpc_pkg::RILPC_ST_RUN)
                         || (s_q.st == rilpc_pkg::RILPC_ST_WAIT);
    assign osc_enable = s_q.osc_run;
    assign watchdog_enable = !s_q.cfg[`RILPC_CFG_WDDIS];
    assign watchdog_tick = s_q.wd_tick;
    assign monitor_mode = s_q.monitor;

endmodule : rilpc_top
`default_nettype wire

//--- pkg/rilpc_map.svh
// register offsets, field positions, reset values and timing counts of the reset/interrupt block
`ifndef RILPC_MAP_SVH
`define RILPC_MAP_SVH

// ----------------------------------------------------------------
// register word byte addresses
// ----------------------------------------------------------------
`define RILPC_ADDR_CAUSE 4'h0
`define RILPC_ADDR_CONFIG 4'h4
`define RILPC_ADDR_STATUS 4'h8
`define RILPC_ADDR_PEND 4'hc

// ----------------------------------------------------------------
// reset cause register bit positions
// ----------------------------------------------------------------
`define RILPC_CAUSE_POR 7
`define RILPC_CAUSE_WDOG 6
`define RILPC_CAUSE_ILLEGAL_OPCODE_FLAG 5
`define RILPC_CAUSE_ILLEGAL_ADDRESS_FLAG 4
`define RILPC_CAUSE_MEN 3
`define RILPC_CAUSE_LVR 1
`define RILPC_CAUSE_PORVAL 8'h80

// ----------------------------------------------------------------
// option register one bit positions and reset value
// ----------------------------------------------------------------
`define RILPC_CFG_SHORT_RECOVERY_SELECT 0
`define RILPC_CFG_STOPEN 1
`define RILPC_CFG_WDDIS 2
`define RILPC_CFG_LVPWRD 3
`define RILPC_CFG_LVRSTD 4
`define RILPC_CFG_OSCSTOP 5
`define RILPC_CFG_RESET 8'h00

// ----------------------------------------------------------------
// timing counts in oscillator source clock cycles
// ----------------------------------------------------------------
`define RILPC_LONG_CYC 4096
`define RILPC_SHORT_CYC 32
`define RILPC_VEC_CYC 64
`define RILPC_ERASED_BYTE 8'hff

`endif

//--- pkg/rilpc_pkg.sv
// types of the reset, interrupt and low-power control block
`default_nettype none
package rilpc_pkg;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        RILPC_ST_RESET,
        RILPC_ST_VEC,
        RILPC_ST_RUN,
        RILPC_ST_WAIT,
        RILPC_ST_STOP,
        RILPC_ST_RECOV
    } rilpc_state_t;

    // ----------------------------------------------------------------
    // cpu status carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic insn_done;
        logic illegal_op;
        logic stop_op;
        logic wait_op;
        logic swi_op;
        logic rti_done;
        logic opcode_fetch;
        logic unmapped;
        logic vec_fetch;
        logic [7:0] vec_data;
        logic [15:0] pc;
        logic i_mask;
    } rilpc_cpu_t;

    // ----------------------------------------------------------------
    // interrupt answer carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic take;
        logic is_swi;
        logic [3:0] vector;
        logic [15:0] ret_pc;
        logic clr_mask;
    } rilpc_irq_t;

    // ----------------------------------------------------------------
    // whole state of the block
    // ----------------------------------------------------------------
    typedef struct packed {
        rilpc_state_t st;
        logic [11:0] cnt;
        logic [12:0] tmr;
        logic [7:0] cause;
        logic [7:0] cfg;
        logic monitor;
        logic lv_hold;
        logic latched;
        logic [3:0] lat_vec;
        rilpc_irq_t irq;
        logic [31:0] rdata;
        logic rvalid;
        logic wd_tick;
        logic osc_run;
    } rilpc_state_all_t;

endpackage : rilpc_pkg
`default_nettype wire

//--- test/rilpc_monitor.sv
// assertion checker on the ports of the reset, interrupt and low-power block
`default_nettype none
module rilpc_monitor #(
    parameter int NSRC = 16,
    parameter int LONG_CYC = 4096
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    // reset sources
    input wire logic power_on_pulse,
    input wire logic low_voltage_in,
    input wire logic watchdog_timeout,
    // cpu side
    input wire rilpc_pkg::rilpc_cpu_t cpu,
    input wire rilpc_pkg::rilpc_irq_t irq,
    // clock and reset controls
    input wire logic internal_reset,
    input wire logic cpu_clk_en,
    input wire logic watchdog_tick
);
    localparam int VEC_CYC = 64;
    default clocking @(posedge core_clk);
    endclocking
    // consecutive cycles with the internal reset high
    int unsigned rst_run_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rst_run_q <= 0;
        end else if (clk_en) begin
            rst_run_q <= internal_reset ? rst_run_q + 1 : 0;
        end
    end
    default disable iff (rst);
    // running cycle with no other reset source active
    logic calm;
    assign calm = clk_en && !internal_reset && !power_on_pulse && !low_voltage_in
        && !watchdog_timeout;
    // ----------------------------------------------------------------
    // interrupt answers, reset and low-power checks
    // ----------------------------------------------------------------
    sequence s_hw_take;
        irq.take && !irq.is_swi;
    endsequence
    sequence s_swi_take;
        irq.take && irq.is_swi;
    endsequence
    property p_illegal_opcode_flag;
        calm && cpu.illegal_op |-> ##[1:2] internal_reset;
    endproperty
    a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("no reset after illegal opcode");
    property p_data;
        calm && cpu.unmapped && !cpu.opcode_fetch && !cpu.illegal_op && !cpu.stop_op
            |=> !internal_reset;
    endproperty
    a_data: assert property (p_data) else $error("data fetch caused reset");
    property p_mask;
        s_hw_take |-> !$past(cpu.i_mask);
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt taken while masked");
    property p_hw_pc;
        s_hw_take |-> irq.ret_pc == $past(cpu.pc) - 16'h0001;
    endproperty
    a_hw_pc: assert property (p_hw_pc) else $error("hardware return pc wrong");
    property p_swi;
        calm && cpu.swi_op && cpu.insn_done |=> s_swi_take ##0 irq.ret_pc == $past(cpu.pc);
    endproperty
    a_swi: assert property (p_swi) else $error("software trap not taken");
    property p_hold;
        $fell(internal_reset) |-> rst_run_q >= LONG_CYC + VEC_CYC;
    endproperty
    a_hold: assert property (p_hold) else $error("vector phase too short");
    property p_clr;
        irq.clr_mask |-> ##[0:1] !cpu_clk_en;
    endproperty
    a_clr: assert property (p_clr) else $error("cpu clock kept in low power");
    property p_tick;
        watchdog_tick |=> !watchdog_tick [*8];
    endproperty
    a_tick: assert property (p_tick) else $error("overflow ticks too close");
    property p_rst_irq;
        internal_reset |-> !irq.take;
    endproperty
    a_rst_irq: assert property (p_rst_irq) else $error("interrupt during reset");
endmodule : rilpc_monitor
bind rilpc_top rilpc_monitor #(.NSRC(NSRC), .LONG_CYC(LONG_CYC)) rilpc_monitor_i (
    .core_clk, .rst, .clk_en, .power_on_pulse, .low_voltage_in, .watchdog_timeout,
    .cpu, .irq, .internal_reset, .cpu_clk_en, .watchdog_tick
);
`default_nettype wire

//--- test/rilpc_cpu_model.sv
// cpu core model turning bench commands into status pulses
`default_nettype none
module rilpc_cpu_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // bench command and levels
    input wire logic [3:0] cmd,
    input wire logic [15:0] pc_set,
    input wire logic [7:0] vec_byte,
    // device side
    input wire rilpc_pkg::rilpc_irq_t irq,
    output rilpc_pkg::rilpc_cpu_t cpu
);
    // one pulse per command; mask set on take or command b, cleared by return, low power or command a
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cpu <= '0;
            cpu.i_mask <= 1'b1;
        end else begin
            cpu.insn_done <= cmd inside {4'h1, 4'h3, 4'h4, 4'h5, 4'h6};
            cpu.illegal_op <= cmd == 4'h2;
            cpu.stop_op <= cmd == 4'h3;
            cpu.wait_op <= cmd == 4'h4;
            cpu.swi_op <= cmd == 4'h5;
            cpu.rti_done <= cmd == 4'h6;
            cpu.opcode_fetch <= cmd == 4'h7;
            cpu.unmapped <= cmd inside {4'h7, 4'h8};
            cpu.vec_fetch <= cmd == 4'h9;
            cpu.vec_data <= (cmd == 4'h9) ? vec_byte : ~vec_byte; // released bus inverts
            cpu.pc <= pc_set;
            if (irq.take || cmd == 4'hb) cpu.i_mask <= 1'b1;
            else if (irq.clr_mask || cmd inside {4'h6, 4'ha}) cpu.i_mask <= 1'b0;
        end
    end
endmodule : rilpc_cpu_model
`default_nettype wire

//--- test/rilpc_top_bench.sv
// self-checking bench of the reset, interrupt and low-power block
`default_nettype none
module rilpc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int L = 40;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic low_voltage_in = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] irq_req = 4'h0;
    logic [3:0] irq_en = 4'h0;
    logic [3:0] cmd = 4'h0;
    logic [7:0] vec_byte = 8'h00;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, internal_reset, cpu_clk_en, periph_clk_en, osc_enable;
    logic watchdog_enable, watchdog_tick, monitor_mode;
    rilpc_pkg::rilpc_cpu_t cpu;
    rilpc_pkg::rilpc_irq_t irq;
    int err_count = 0;
    int checks = 0;
    int n;
    // 50 ns clock
    always #25 core_clk = ~core_clk;
    // device and cpu model
    rilpc_top #(.NSRC(4), .LONG_CYC(L)) rilpc_top_i (
        .core_clk, .clk_en(1'b1), .rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .power_on_pulse(1'b0), .low_voltage_in, .watchdog_timeout(1'b0), .cpu, .irq,
        .irq_req, .irq_en, .internal_reset, .cpu_clk_en, .periph_clk_en, .osc_enable,
        .watchdog_enable, .watchdog_tick, .monitor_mode
    );
    rilpc_cpu_model rilpc_cpu_model_i (
        .core_clk, .rst, .cmd, .pc_set(16'h1234), .vec_byte, .irq, .cpu
    );
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic print_verdict();
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    task automatic fail();
        err_count++;
        print_verdict();
    endtask : fail
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
    endtask : step
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= 4'h1;
        avs_read <= !w;
        avs_write <= w;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (n > 20) fail();
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk
    task automatic op(input logic [3:0] c);
        @(posedge core_clk);
        cmd <= c;
        @(posedge core_clk);
        cmd <= 4'h0;
    endtask : op
    task automatic settle();
        n = 0;
        while (internal_reset !== 1'b0) begin
            @(posedge core_clk);
            n++;
            if (n > 3000) fail();
        end
    endtask : settle
    task automatic hit(input logic [3:0] c);
        op(c);
        step(2);
        chk(32'(internal_reset), 32'h1);
        settle();
    endtask : hit
    task automatic await_take(input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge core_clk);
            if (irq.take === 1'b1) break;
        end
    endtask : await_take
    task automatic tk(input int lim, input logic [20:0] e);
        await_take(lim);
        chk(32'({n <= lim, irq.is_swi, irq.vector, irq.ret_pc}), 32'({1'b1, e}));
    endtask : tk
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        step(5);
        rst <= 1'b0;
        settle();
        chk(32'(n >= L + 64 && n <= L + 66), 32'h1);
        rchk(4'h0, 32'h80);
        rchk(4'h0, 32'h00);
        rchk(4'h2, 32'h00);
        rchk(4'h4, 32'h00);
        hit(4'h2);
        rchk(4'h0, 32'h20);
        hit(4'h3);
        op(4'h8);
        step(3);
        chk(32'(internal_reset), 32'h0);
        hit(4'h7);
        rchk(4'h0, 32'h30);
        bus(1'b1, 4'h4, 32'h08);
        low_voltage_in <= 1'b1;
        step(5);
        chk(32'(internal_reset), 32'h0);
        bus(1'b1, 4'h4, 32'h10);
        step(5);
        chk(32'(internal_reset), 32'h0);
        bus(1'b1, 4'h4, 32'h00);
        step(3);
        chk(32'(internal_reset), 32'h1);
        low_voltage_in <= 1'b0;
        settle();
        chk(32'(n >= L + 64 && n <= L + 66), 32'h1);
        rchk(4'h0, 32'h02);
        irq_req <= 4'b0100;
        irq_en <= 4'hf;
        op(4'ha);
        step(1);
        irq_req <= 4'b0110;
        op(4'h1);
        tk(6, {1'b0, 4'h2, 16'h1233});
        op(4'ha);
        op(4'h1);
        tk(6, {1'b0, 4'h1, 16'h1233});
        op(4'h1);
        await_take(6);
        chk(32'(n), 32'h7);
        irq_en <= 4'h0;
        op(4'ha);
        op(4'h1);
        await_take(6);
        chk(32'(n), 32'h7);
        op(4'hb);
        op(4'h5);
        tk(6, {1'b1, 4'h0, 16'h1234});
        irq_en <= 4'hf;
        op(4'h6);
        tk(6, {1'b0, 4'h1, 16'h1233});
        irq_en <= 4'h0;
        op(4'h4);
        step(2);
        chk(32'({cpu_clk_en, periph_clk_en, watchdog_enable}), 32'h3);
        irq_en <= 4'hf;
        tk(4, {1'b0, 4'h1, 16'h1233});
        irq_en <= 4'h0;
        bus(1'b1, 4'h4, 32'h03);
        op(4'h3);
        step(2);
        chk(32'({cpu_clk_en, periph_clk_en, osc_enable}), 32'h0);
        irq_en <= 4'hf;
        await_take(60);
        chk(32'(n >= 32 && n <= 40), 32'h1);
        irq_en <= 4'h0;
        bus(1'b1, 4'h4, 32'h26);
        step(1);
        chk(32'(watchdog_enable), 32'h0);
        op(4'h3);
        step(2);
        chk(32'(osc_enable), 32'h1);
        irq_en <= 4'hf;
        await_take(L + 30);
        chk(32'(n >= L && n <= L + 8), 32'h1);
        n = 0;
        for (int k = 0; k < 4200; k++) begin
            @(posedge core_clk);
            if (watchdog_tick === 1'b1) n++;
        end
        chk(32'(n >= 1 && n <= 2), 32'h1);
        rst <= 1'b1;
        step(5);
        rst <= 1'b0;
        step(L + 10);
        vec_byte <= 8'hff;
        op(4'h9);
        settle();
        chk(32'(monitor_mode), 32'h1);
        rchk(4'h0, 32'h88);
        print_verdict();
    end
endmodule : rilpc_top_bench
`default_nettype wire
